// ==== verilog/dtc_pkg.sv ====
// constants and types shared by the dual timer/counter block
`default_nettype none

package dtc_pkg;

	// ------------------------------------------------------------
	// special function register addresses
	// ------------------------------------------------------------
	localparam int unsigned SFR_AW        = 8;
	localparam int unsigned SFR_DW        = 8;
	localparam logic [7:0]  ADDR_CTRL     = 8'h88;  // timer_irq_control
	localparam logic [7:0]  ADDR_MODE     = 8'h89;  // timer_mode_config
	localparam logic [7:0]  ADDR_T0_LOW   = 8'h8a;  // timer0_count_low
	localparam logic [7:0]  ADDR_T1_LOW   = 8'h8b;  // timer1_count_low
	localparam logic [7:0]  ADDR_T0_HIGH  = 8'h8c;  // timer0_count_high
	localparam logic [7:0]  ADDR_T1_HIGH  = 8'h8d;  // timer1_count_high

	// ------------------------------------------------------------
	// values after reset and for unmapped reads
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_CTRL      = 8'h00;
	localparam logic [7:0]  RST_MODE      = 8'h00;
	localparam logic [7:0]  RST_COUNT     = 8'h00;
	localparam logic [7:0]  RST_RDATA     = 8'h00;
	localparam logic        RST_PIN_LEVEL = 1'b1;   // pins idle high
	localparam logic [7:0]  READ_UNMAPPED = 8'h00;

	// ------------------------------------------------------------
	// timer_irq_control field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_OVF1     = 7;
	localparam int unsigned CTRL_RUN1     = 6;
	localparam int unsigned CTRL_OVF0     = 5;
	localparam int unsigned CTRL_RUN0     = 4;
	localparam int unsigned CTRL_IRQ1_REQ = 3;
	localparam int unsigned CTRL_IRQ1_TYP = 2;
	localparam int unsigned CTRL_IRQ0_REQ = 1;
	localparam int unsigned CTRL_IRQ0_TYP = 0;

	// ------------------------------------------------------------
	// timer_mode_config field positions
	// ------------------------------------------------------------
	localparam int unsigned MODE_GATE1    = 7;
	localparam int unsigned MODE_SEL1     = 6;
	localparam int unsigned MODE_FLD1_LSB = 4;
	localparam int unsigned MODE_GATE0    = 3;
	localparam int unsigned MODE_SEL0     = 2;
	localparam int unsigned MODE_FLD0_LSB = 0;
	localparam int unsigned MODE0_LOW_BITS = 5;     // low byte bits used in 13-bit mode

	// mode_field encodings
	typedef enum logic [1:0] {
		DTC_MODE_13   = 2'b00,
		DTC_MODE_16   = 2'b01,
		DTC_MODE_AUTO = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_t;

endpackage

`default_nettype wire

// ==== verilog/dtc_pin_sample.sv ====
// one machine-cycle sampler with falling-edge detect for an external pin
`timescale 1ns/1ps
`default_nettype none

module dtc_pin_sample (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic pin,
	output var  logic level,
	output var  logic fall
);
	import dtc_pkg::*;

	typedef struct packed {
		logic level;
		logic fall;
	} dtc_pin_state_t;

	dtc_pin_state_t s;
	dtc_pin_state_t next_s;

	// ------------------------------------------------------------
	// sampling
	// ------------------------------------------------------------
	// a fall is a high sample followed by a low one, so a glitch shorter
	// than a machine cycle may be missed entirely
	always_comb begin
		next_s       = s;
		next_s.level = pin;
		next_s.fall  = s.level & ~pin;
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s.level <= RST_PIN_LEVEL;
			s.fall  <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.level;
	assign fall  = s.fall;

	a_fall_sample: assert property (@(posedge clock) disable iff (!rst_n)
		fall |-> (!level && $past(level)))
		else $error("fall pulse without a high then low sample");

endmodule // dtc_pin_sample

`default_nettype wire

// ==== verilog/dtc_timer_pair.sv ====
// two timer/counters with run, gating, modes and external interrupt flags
`timescale 1ns/1ps
`default_nettype none

module dtc_timer_pair (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic [dtc_pkg::SFR_AW-1:0] sfr_addr,
	input  wire logic                       sfr_wr,
	input  wire logic [dtc_pkg::SFR_DW-1:0] sfr_wdata,
	output var  logic [dtc_pkg::SFR_DW-1:0] sfr_rdata,
	input  wire logic                       count_pin_0,
	input  wire logic                       count_pin_1,
	input  wire logic                       ext_irq0_pin,
	input  wire logic                       ext_irq1_pin,
	input  wire logic                       vector_ack_t0,
	input  wire logic                       vector_ack_t1,
	input  wire logic                       vector_ack_irq0,
	input  wire logic                       vector_ack_irq1,
	output var  logic                       overflow_flag_t0,
	output var  logic                       overflow_flag_t1,
	output var  logic                       ext_irq0_request,
	output var  logic                       ext_irq1_request,
	output var  logic                       t1_baud_tick
);
	import dtc_pkg::*;

	typedef struct packed {
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [7:0] timer_mode_config;
		logic [7:0] timer_irq_control;
		logic [7:0] rdata;
		logic       baud;
	} dtc_state_t;

	dtc_state_t s;
	dtc_state_t next_s;

	logic       cnt0_fall;
	logic       cnt1_fall;
	logic       irq0_lvl;
	logic       irq0_fall;
	logic       irq1_lvl;
	logic       irq1_fall;
	dtc_mode_t  mode0;
	dtc_mode_t  mode1;
	logic       split0;
	logic       en0;
	logic       en1;
	logic       wr_t0;
	logic       wr_t1;
	logic       wr_ctrl;

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	// the external source must hold each level a full machine cycle
	dtc_pin_sample u_cnt0 (.clock(clock), .rst_n(rst_n), .pin(count_pin_0), .level(), .fall(cnt0_fall));
	dtc_pin_sample u_cnt1 (.clock(clock), .rst_n(rst_n), .pin(count_pin_1), .level(), .fall(cnt1_fall));
	dtc_pin_sample u_irq0 (.clock(clock), .rst_n(rst_n), .pin(ext_irq0_pin), .level(irq0_lvl), .fall(irq0_fall));
	dtc_pin_sample u_irq1 (.clock(clock), .rst_n(rst_n), .pin(ext_irq1_pin), .level(irq1_lvl), .fall(irq1_fall));

	// ------------------------------------------------------------
	// count enables
	// ------------------------------------------------------------
	// one clock is one machine cycle on the single-cycle core
	assign mode0  = dtc_mode_t'(s.timer_mode_config[MODE_FLD0_LSB +: 2]);
	assign mode1  = dtc_mode_t'(s.timer_mode_config[MODE_FLD1_LSB +: 2]);
	assign split0 = (mode0 == DTC_MODE_SPLIT);
	assign en0    = s.timer_irq_control[CTRL_RUN0] & (~s.timer_mode_config[MODE_GATE0] | irq0_lvl)
	                & (s.timer_mode_config[MODE_SEL0] ? cnt0_fall : 1'b1);
	// with timer 0 split, timer 1 loses its run bit but keeps its gate and pin select; mode three holds it
	assign en1    = (split0 ? 1'b1 : s.timer_irq_control[CTRL_RUN1]) & (~s.timer_mode_config[MODE_GATE1] | irq1_lvl)
	                & (s.timer_mode_config[MODE_SEL1] ? cnt1_fall : 1'b1);
	assign wr_t0  = sfr_wr && (sfr_addr == ADDR_T0_LOW || sfr_addr == ADDR_T0_HIGH);
	assign wr_t1  = sfr_wr && (sfr_addr == ADDR_T1_LOW || sfr_addr == ADDR_T1_HIGH);
	assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CTRL);

	// ------------------------------------------------------------
	// one count step: returns {carry, high, low}
	// ------------------------------------------------------------
	// the same step serves both timers, so modes 0 to 2 match by construction; in mode three timer 0 splits while timer 1 holds
	function automatic logic [16:0] dtc_step(dtc_mode_t m, logic [7:0] hi, logic [7:0] lo, logic en);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		logic [16:0] r;
		s13 = {1'b0, hi, lo[MODE0_LOW_BITS-1:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h0_0001;
		s8  = {1'b0, lo} + 9'h001;
		r   = {1'b0, hi, lo};
		if (en) begin
			unique case (m)
				// upper three low bits are left untouched and mean nothing
				DTC_MODE_13:    r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
				DTC_MODE_16:    r = s16;
				DTC_MODE_AUTO:  r = {s8[8], hi, (s8[8] ? hi : s8[7:0])};
				DTC_MODE_SPLIT: r = {1'b0, hi, lo};
			endcase
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [16:0] st0;
		logic [16:0] st1;
		logic [8:0]  lo_split;
		logic [8:0]  hi_split;
		logic        ovf0;
		logic        ovf1;
		next_s      = s;
		st0         = dtc_step(mode0, s.th0, s.tl0, en0);
		st1         = dtc_step(mode1, s.th1, s.tl1, en1);
		lo_split    = {1'b0, s.tl0} + 9'h001;
		hi_split    = {1'b0, s.th0} + 9'h001;
		ovf0        = st0[16];
		ovf1        = st1[16];
		next_s.baud = st1[16];
		next_s.tl0  = st0[7:0];
		next_s.th0  = st0[15:8];
		next_s.tl1  = st1[7:0];
		next_s.th1  = st1[15:8];
		if (split0) begin
			// low byte keeps timer 0 controls, high byte counts cycles on run1
			ovf0 = en0 & lo_split[8];
			next_s.tl0 = en0 ? lo_split[7:0] : s.tl0;
			ovf1 = s.timer_irq_control[CTRL_RUN1] & hi_split[8];
			next_s.th0 = s.timer_irq_control[CTRL_RUN1] ? hi_split[7:0] : s.th0;
		end
		// software writes take precedence over a count in the same cycle
		if (sfr_wr) begin
			unique case (sfr_addr)
				ADDR_T0_LOW:  next_s.tl0 = sfr_wdata;
				ADDR_T0_HIGH: next_s.th0 = sfr_wdata;
				ADDR_T1_LOW:  next_s.tl1 = sfr_wdata;
				ADDR_T1_HIGH: next_s.th1 = sfr_wdata;
				ADDR_MODE:    next_s.timer_mode_config = sfr_wdata;
				ADDR_CTRL:    next_s.timer_irq_control = sfr_wdata;
				default:      next_s.timer_mode_config = s.timer_mode_config;
			endcase
		end
		// overflow flags: vector clears, a same-cycle overflow wins
		if (vector_ack_t0) next_s.timer_irq_control[CTRL_OVF0] = 1'b0;
		if (ovf0) next_s.timer_irq_control[CTRL_OVF0] = 1'b1;
		if (vector_ack_t1) next_s.timer_irq_control[CTRL_OVF1] = 1'b0;
		if (ovf1) next_s.timer_irq_control[CTRL_OVF1] = 1'b1;
		// external request flags; level mode tracks the pin, edge mode is sticky
		if (next_s.timer_irq_control[CTRL_IRQ0_TYP]) begin
			if (vector_ack_irq0) next_s.timer_irq_control[CTRL_IRQ0_REQ] = 1'b0;
			if (irq0_fall) next_s.timer_irq_control[CTRL_IRQ0_REQ] = 1'b1;
		end else begin
			next_s.timer_irq_control[CTRL_IRQ0_REQ] = ~irq0_lvl;
		end
		if (next_s.timer_irq_control[CTRL_IRQ1_TYP]) begin
			if (vector_ack_irq1) next_s.timer_irq_control[CTRL_IRQ1_REQ] = 1'b0;
			if (irq1_fall) next_s.timer_irq_control[CTRL_IRQ1_REQ] = 1'b1;
		end else begin
			next_s.timer_irq_control[CTRL_IRQ1_REQ] = ~irq1_lvl;
		end
		// read data shows the state before this cycle's update
		unique case (sfr_addr)
			ADDR_CTRL:    next_s.rdata = s.timer_irq_control;
			ADDR_MODE:    next_s.rdata = s.timer_mode_config;
			ADDR_T0_LOW:  next_s.rdata = s.tl0;
			ADDR_T1_LOW:  next_s.rdata = s.tl1;
			ADDR_T0_HIGH: next_s.rdata = s.th0;
			ADDR_T1_HIGH: next_s.rdata = s.th1;
			default:      next_s.rdata = READ_UNMAPPED;
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s.tl0   <= RST_COUNT;
			s.th0   <= RST_COUNT;
			s.tl1   <= RST_COUNT;
			s.th1   <= RST_COUNT;
			s.timer_mode_config  <= RST_MODE;
			s.timer_irq_control  <= RST_CTRL;
			s.rdata <= RST_RDATA;
			s.baud  <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign sfr_rdata        = s.rdata;
	assign overflow_flag_t0 = s.timer_irq_control[CTRL_OVF0];
	assign overflow_flag_t1 = s.timer_irq_control[CTRL_OVF1];
	assign ext_irq0_request = s.timer_irq_control[CTRL_IRQ0_REQ];
	assign ext_irq1_request = s.timer_irq_control[CTRL_IRQ1_REQ];
	assign t1_baud_tick     = s.baud;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking dtc_cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_t0_stop_holds: assert property (
		(!s.timer_irq_control[CTRL_RUN0] && !split0 && !wr_t0) |=> ($stable(s.tl0) && $stable(s.th0)))
		else $error("timer 0 moved while stopped");
	a_gate_blocks: assert property (
		(s.timer_mode_config[MODE_GATE0] && !irq0_lvl && !split0 && !wr_t0) |=> ($stable(s.tl0) && $stable(s.th0)))
		else $error("timer 0 counted with gate closed");
	a_mode1_incr: assert property (
		(mode0 == DTC_MODE_16 && en0 && !wr_t0) |=> ({s.th0, s.tl0} == $past({s.th0, s.tl0}) + 16'h0001))
		else $error("16-bit count did not step by one");
	a_mode0_wrap: assert property (
		(mode0 == DTC_MODE_13 && en0 && !wr_t0 && !wr_ctrl && s.th0 == 8'hff && s.tl0[4:0] == 5'h1f)
		|=> (s.th0 == 8'h00 && s.tl0[4:0] == 5'h00 && s.timer_irq_control[CTRL_OVF0]))
		else $error("13-bit wrap wrong");
	a_mode2_reload: assert property (
		(mode0 == DTC_MODE_AUTO && en0 && !wr_t0 && !wr_ctrl && s.tl0 == 8'hff)
		|=> (s.tl0 == $past(s.th0) && $stable(s.th0) && s.timer_irq_control[CTRL_OVF0]))
		else $error("auto reload wrong");
	a_t1_mode3_hold: assert property (
		(mode1 == DTC_MODE_SPLIT && !wr_t1) |=> ($stable(s.tl1) && $stable(s.th1) && !s.baud))
		else $error("timer 1 moved in mode three");
	a_split_high_ovf: assert property (
		(split0 && s.timer_irq_control[CTRL_RUN1] && s.th0 == 8'hff && !wr_t0 && !wr_ctrl) |=> (s.th0 == 8'h00 && overflow_flag_t1))
		else $error("split high byte overflow not on timer 1 flag");
	a_irq1_level: assert property (
		(!s.timer_irq_control[CTRL_IRQ1_TYP] && !wr_ctrl) |=> (ext_irq1_request == !$past(irq1_lvl)))
		else $error("level request does not follow pin");
	a_irq0_edge_set: assert property (
		(s.timer_irq_control[CTRL_IRQ0_TYP] && irq0_fall && !wr_ctrl) |=> ext_irq0_request)
		else $error("edge request not set");
	a_irq0_edge_ack: assert property (
		(s.timer_irq_control[CTRL_IRQ0_TYP] && vector_ack_irq0 && !irq0_fall && !wr_ctrl) |=> !ext_irq0_request)
		else $error("edge request not cleared by vector");
	a_ovf_ack_clear: assert property (
		(vector_ack_t0 && !en0 && !wr_ctrl) |=> !overflow_flag_t0)
		else $error("overflow flag not cleared by vector");

	c_t0_overflow:  cover property (!overflow_flag_t0 ##1 overflow_flag_t0);
	c_reload:       cover property (mode0 == DTC_MODE_AUTO && en0 && s.tl0 == 8'hff);
	c_split_run:    cover property (split0 && s.timer_irq_control[CTRL_RUN1] && en1 && mode1 != DTC_MODE_SPLIT);
	c_edge_request: cover property (s.timer_irq_control[CTRL_IRQ1_TYP] && irq1_fall);

endmodule // dtc_timer_pair

`default_nettype wire

// ==== dv/dtc_pin_model.sv ====
// board-side model driving the count and interrupt pins
`timescale 1ns/1ps
`default_nettype none

module dtc_pin_model (
	input  wire logic       clock,
	output var  logic [3:0] pins
);
	import dtc_pkg::*;

	// ----------------------------------------
	// pin drive: [0] count0 [1] count1 [2] irq0 [3] irq1
	// ----------------------------------------
	// pull-ups keep every pin high while idle
	initial begin
		pins = {4{RST_PIN_LEVEL}};
	end

	// each low level stands w whole cycles and each high level at least w, so the sampler never misses it
	task automatic pulse(input int idx, input int n, input int w);
		for (int k = 0; k < n; k++) begin
			@(negedge clock);
			pins[idx] = 1'b0;
			repeat (w) @(negedge clock);
			pins[idx] = 1'b1;
			repeat (w) @(negedge clock);
		end
	endtask

	// a level source drives its pin to lvl and leaves it there until the next call
	task automatic hold(input int idx, input logic lvl);
		@(negedge clock);
		pins[idx] = lvl;
	endtask
endmodule // dtc_pin_model

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking testbench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none

module tb;
	import dtc_pkg::*;

	logic       clock;
	logic       rst_n;
	logic       sfr_wr;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic [3:0] ack;
	logic [3:0] pins;
	logic       overflow_flag_t0;
	logic       overflow_flag_t1;
	logic       ext_irq0_request;
	logic       ext_irq1_request;
	logic       t1_baud_tick;
	int         errors;
	int         tests_run;

	dtc_timer_pair i_dut (
		.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .count_pin_0(pins[0]), .count_pin_1(pins[1]), .ext_irq0_pin(pins[2]),
		.ext_irq1_pin(pins[3]), .vector_ack_t0(ack[0]), .vector_ack_t1(ack[1]), .vector_ack_irq0(ack[2]),
		.vector_ack_irq1(ack[3]), .overflow_flag_t0(overflow_flag_t0), .overflow_flag_t1(overflow_flag_t1),
		.ext_irq0_request(ext_irq0_request), .ext_irq1_request(ext_irq1_request), .t1_baud_tick(t1_baud_tick)
	);

	dtc_pin_model i_pins (
		.clock(clock),
		.pins(pins)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// writes are spaced two cycles apart so wr never toggles twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask

	// read data is registered: settled one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		@(negedge clock);
		d = sfr_rdata;
	endtask

	task automatic setup(input logic [7:0] mode, input logic [7:0] hi, input logic [7:0] lo);
		wr(ADDR_MODE, mode);
		wr(ADDR_T0_HIGH, hi);
		wr(ADDR_T0_LOW, lo);
	endtask

	// counts exactly 'cycles' times; flags sampled after cycles-2 counts
	task automatic run(input logic [7:0] on, input logic [7:0] off, input int cycles, output logic [1:0] f);
		wr(ADDR_CTRL, on);
		repeat (cycles - 2) @(negedge clock);
		f = {overflow_flag_t1, overflow_flag_t0};
		wr(ADDR_CTRL, off);
	endtask

	task automatic pulse_ack(input int idx);
		@(negedge clock);
		ack[idx] = 1'b1;
		@(negedge clock);
		ack[idx] = 1'b0;
		@(negedge clock);
	endtask

	function automatic logic req(input int idx);
		return idx ? ext_irq1_request : ext_irq0_request;
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_reset();
		logic [7:0] v;
		logic [7:0] addrs [7] = '{ADDR_CTRL, ADDR_MODE, ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH, ADDR_T1_HIGH, 8'h90};
		foreach (addrs[i]) begin
			rd(addrs[i], v);
			check("reset value", 8'h00, v);
		end
		check("outputs", 8'h00, {3'b000, overflow_flag_t0, overflow_flag_t1, ext_irq0_request, ext_irq1_request,
			t1_baud_tick});
	endtask

	// 16-bit wrap from a loaded value, stop, then vector clears the flag
	task automatic s_mode1();
		logic [7:0] v;
		logic [1:0] f;
		setup(8'h01, 8'hff, 8'hfe);
		run(8'h10, 8'h20, 5, f);
		check("t0 overflow", 8'h01, {7'h00, f[0]});
		rd(ADDR_T0_HIGH, v);
		check("t0 high", 8'h00, v);
		repeat (4) @(negedge clock);
		rd(ADDR_T0_LOW, v);
		check("t0 low", 8'h03, v);
		pulse_ack(0);
		check("t0 flag cleared", 8'h00, {7'h00, overflow_flag_t0});
	endtask

	// upper three low-byte bits are masked out of the 13-bit compare
	task automatic s_mode0();
		logic [7:0] v;
		logic [1:0] f;
		setup(8'h00, 8'hff, 8'hff);
		run(8'h10, 8'h00, 5, f);
		check("mode0 overflow", 8'h01, {7'h00, f[0]});
		rd(ADDR_T0_HIGH, v);
		check("mode0 high", 8'h00, v);
		rd(ADDR_T0_LOW, v);
		check("mode0 low", 8'h04, v & 8'h1f);
	endtask

	task automatic s_mode2();
		logic [7:0] v;
		logic [1:0] f;
		setup(8'h02, 8'hf0, 8'hfe);
		run(8'h10, 8'h00, 5, f);
		check("reload overflow", 8'h01, {7'h00, f[0]});
		rd(ADDR_T0_LOW, v);
		check("reload low", 8'hf3, v);
		rd(ADDR_T0_HIGH, v);
		check("reload high", 8'hf0, v);
	endtask

	// timer 1 in 16-bit mode, then held by its own mode three
	task automatic s_timer1();
		logic [7:0] v;
		logic [1:0] f;
		wr(ADDR_MODE, 8'h10);
		wr(ADDR_T1_HIGH, 8'hff);
		wr(ADDR_T1_LOW, 8'hfe);
		run(8'h40, 8'h00, 5, f);
		check("t1 overflow", 8'h01, {7'h00, f[1]});
		rd(ADDR_T1_LOW, v);
		check("t1 low", 8'h03, v);
		wr(ADDR_MODE, 8'h30);
		run(8'h40, 8'h00, 5, f);
		rd(ADDR_T1_LOW, v);
		check("t1 held", 8'h03, v);
	endtask

	task automatic s_gate();
		logic [7:0] v;
		logic [1:0] f;
		setup(8'h09, 8'h00, 8'h00);
		i_pins.hold(2, 1'b0);
		run(8'h10, 8'h00, 6, f);
		rd(ADDR_T0_LOW, v);
		check("gate closed", 8'h00, v);
		i_pins.hold(2, 1'b1);
		repeat (2) @(negedge clock);
		run(8'h10, 8'h00, 6, f);
		rd(ADDR_T0_LOW, v);
		check("gate open", 8'h06, v);
	endtask

	task automatic s_counter();
		logic [7:0] v;
		setup(8'h05, 8'h00, 8'h00);
		wr(ADDR_CTRL, 8'h10);
		i_pins.pulse(0, 3, 2);
		repeat (3) @(negedge clock);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_T0_LOW, v);
		check("pin falls", 8'h03, v);
	endtask

	// split timer 0: low byte on timer 0 controls, high byte on run1/flag1
	task automatic s_split();
		logic [7:0] v;
		logic [1:0] f;
		int         n;
		n = 0;
		setup(8'h03, 8'hfe, 8'h00);
		// the stop write keeps the timer 1 flag so the vector clear can be seen
		run(8'h50, 8'h80, 5, f);
		check("split flags", 8'h02, {6'h00, f});
		rd(ADDR_T0_LOW, v);
		check("split low", 8'h05, v);
		rd(ADDR_T0_HIGH, v);
		check("split high", 8'h03, v);
		check("t1 flag held", 8'h01, {7'h00, overflow_flag_t1});
		pulse_ack(1);
		check("t1 flag cleared", 8'h00, {7'h00, overflow_flag_t1});
		// timer 1 keeps running for baud timing while timer 0 is split
		while (t1_baud_tick !== 1'b1 && n < 9000) begin
			@(negedge clock);
			n++;
		end
		check("t1 baud tick", 8'h01, {7'h00, t1_baud_tick});
		check("t1 no flag", 8'h00, {7'h00, overflow_flag_t1});
	endtask

	// edge requests latch until vectored; level requests follow the pin
	task automatic s_irq();
		for (int idx = 0; idx < 2; idx++) begin
			wr(ADDR_CTRL, idx ? 8'h04 : 8'h01);
			i_pins.pulse(2 + idx, 1, 2);
			check("edge request", 8'h01, {7'h00, req(idx)});
			pulse_ack(2 + idx);
			check("edge cleared", 8'h00, {7'h00, req(idx)});
			wr(ADDR_CTRL, 8'h00);
			i_pins.hold(2 + idx, 1'b0);
			repeat (3) @(negedge clock);
			check("level request", 8'h01, {7'h00, req(idx)});
			pulse_ack(2 + idx);
			check("level kept", 8'h01, {7'h00, req(idx)});
			i_pins.hold(2 + idx, 1'b1);
			repeat (3) @(negedge clock);
			check("level withdrawn", 8'h00, {7'h00, req(idx)});
		end
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// 200 MHz core clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// a hung run counts as a mismatch
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		conclude();
	end

	// main sequence: reset for five cycles, then each scenario
	initial begin
		errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		sfr_wr = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		ack = 4'h0;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		s_reset();
		s_mode1();
		s_mode0();
		s_mode2();
		s_timer1();
		s_gate();
		s_counter();
		s_split();
		s_irq();
		conclude();
	end
endmodule // tb

`default_nettype wire
